// ==== shared/tac_pkg.sv ====
// How it works
// - Reference power bit switches internal reference
// - Reference mode low routes reference to drivers
// - Acquisition lasts three serial clock cycles
// - Stopped serial clock keeps all state intact
// - Converter power bit keeps drivers energized
// - Drivers held by the converter power bit stay energized until host stops them
// - Channel zero digitizes diode at base current
// - Channel seven digitizes diode at 91x current
// - Diode bias only during acquisition window
// - Pen interrupt diode senses during temperature
// - Twelve-bit code step is reference over 4096
// - Control byte MSB first, fixed bit order
// - Twelve-bit ratiometric conversion needs a thirteenth clock
package tac_pkg;
   localparam int unsigned ACQ_CLOCKS   = 3;
   localparam int unsigned CODE_STEPS   = 4096;
   localparam logic [3:0]  RES12_BITS   = 4'hc;
   localparam logic [3:0]  RES8_BITS    = 4'h8;
   // control byte layout
   localparam int unsigned START_POS    = 7;
   localparam int unsigned CHAN_HI      = 6;
   localparam int unsigned CHAN_LO      = 4;
   localparam int unsigned RES_POS      = 3;
   localparam int unsigned REFMODE_POS  = 2;
   localparam int unsigned REFPWR_POS   = 1;
   localparam int unsigned CONVPWR_POS  = 0;
   // receive counter values at the edges of interest
   localparam logic [3:0]  CNT_ACQ      = 4'h4;
   localparam logic [3:0]  CNT_REFMODE  = 4'h5;
   localparam logic [3:0]  CNT_REFPWR   = 4'h6;
   localparam logic [3:0]  CNT_LAST     = 4'h7;
   // channel codes
   localparam logic [2:0]  CH_TEMP_BASE = 3'h0;
   localparam logic [2:0]  CH_Y_POS     = 3'h1;
   localparam logic [2:0]  CH_Z1_POS    = 3'h3;
   localparam logic [2:0]  CH_Z2_POS    = 3'h4;
   localparam logic [2:0]  CH_X_POS     = 3'h5;
   localparam logic [2:0]  CH_TEMP_X91  = 3'h7;
   // driver enables {x+, x-, y+, y-}
   localparam logic [3:0]  DRV_OFF      = 4'h0;
   localparam logic [3:0]  DRV_Y_PAIR   = 4'h3;
   localparam logic [3:0]  DRV_YP_XN    = 4'h6;
   localparam logic [3:0]  DRV_X_PAIR   = 4'hc;
   // register map
   localparam logic [3:0]  ADDR_STATUS  = 4'h0;
   localparam logic [3:0]  ADDR_RESULT  = 4'h4;
   localparam logic [3:0]  ADDR_CTRL    = 4'h8;
   localparam logic [3:0]  ADDR_FRAMES  = 4'hc;
   localparam int unsigned CTRL_EN_POS  = 0;
   localparam logic        CTRL_EN_RST  = 1'b1;
   localparam logic [15:0] FRAMES_RST   = 16'h0000;

   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_CONV} tac_state_e;
endpackage : tac_pkg

// ==== hdl/tac_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// plain two-flop level synchroniser; only q_o may be read
module tac_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
   end
endmodule : tac_sync
`default_nettype wire

// ==== hdl/tac_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tac_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // serial link, clocked by the host
   input  wire logic        serial_clock_in_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   output logic             dout_o,
   output logic             dout_oe_o,
   output logic             busy_o,
   // analog front end
   input  wire logic        cmp_i,
   output logic             ref_enable_o,
   output logic             ref_ratiometric_o,
   output logic      [2:0]  mux_select_o,
   output logic      [3:0]  drivers_o,
   output logic             temp_bias_base_o,
   output logic             temp_bias_x91_o,
   output logic             pen_diode_sense_o,
   output logic             sample_o
);
   import tac_pkg::*;

   // ---------------- link domain ----------------
   logic [1:0]  lsync;
   logic        lrst;
   logic        lena;
   tac_state_e  state_q;
   logic [3:0]  bit_cnt_q;
   logic [6:0]  cmd_q;
   logic        mode8_q;
   logic        keep_on_q;
   logic [11:0] res_sh_q;
   logic [11:0] result_q;
   logic [7:0]  cmd_done_q;
   logic        done_tgl_q;
   logic [11:0] res_next;
   logic [3:0]  conv_len;
   logic        conv_last;
   logic        ctrl_en_q;

   // reset and enable reach the link clock as levels
   tac_sync #(.W(2)) u_lsync (
      .clk_i (serial_clock_in_i),
      .d_i   ({ctrl_en_q, rst_i}),
      .q_o   (lsync)
   );
   assign lrst = lsync[0];
   assign lena = lsync[1];

   // the extra clock in ratiometric mode delays every decision by one
   assign conv_len  = (mode8_q ? RES8_BITS : RES12_BITS) + {3'h0, ref_ratiometric_o};
   assign conv_last = (bit_cnt_q == conv_len - 4'h1);
   assign res_next  = {res_sh_q[10:0], cmp_i};

   function automatic logic [3:0] drv_for(input logic [2:0] ch);
      case (ch)
         CH_Y_POS:  drv_for = DRV_Y_PAIR;
         CH_Z1_POS: drv_for = DRV_YP_XN;
         CH_Z2_POS: drv_for = DRV_YP_XN;
         CH_X_POS:  drv_for = DRV_X_PAIR;
         default:   drv_for = DRV_OFF;
      endcase
   endfunction : drv_for

   // sequencer; a stopped serial clock simply freezes every register here
   always_ff @(posedge serial_clock_in_i) begin
      if (lrst) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         cmd_q     <= 7'h00;
      end else if (cs_n_i) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 4'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // bits ahead of the first high bit are ignored
               if (lena && din_i) begin
                  state_q   <= ST_CMD;
                  bit_cnt_q <= 4'h1;
               end
            end
            ST_CMD: begin
               cmd_q     <= {cmd_q[5:0], din_i};
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (bit_cnt_q == CNT_LAST) begin
                  state_q   <= ST_CONV;
                  bit_cnt_q <= 4'h0;
               end
            end
            ST_CONV: begin
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (conv_last) begin
                  state_q   <= ST_IDLE;
                  bit_cnt_q <= 4'h0;
               end
            end
            default: begin
               state_q   <= ST_IDLE;
               bit_cnt_q <= 4'h0;
            end
         endcase
      end
   end

   // control fields latched as their bits arrive
   always_ff @(posedge serial_clock_in_i) begin
      if (lrst) begin
         ref_enable_o      <= 1'b0;
         ref_ratiometric_o <= 1'b0;
         mux_select_o      <= 3'h0;
         mode8_q           <= 1'b0;
         keep_on_q         <= 1'b0;
         cmd_done_q        <= 8'h00;
      end else if (!cs_n_i && state_q == ST_CMD) begin
         if (bit_cnt_q == CNT_ACQ) begin
            mux_select_o <= cmd_q[2:0];
            mode8_q      <= din_i;
         end
         if (bit_cnt_q == CNT_REFMODE) begin
            ref_ratiometric_o <= !din_i;
         end
         if (bit_cnt_q == CNT_REFPWR) begin
            ref_enable_o <= din_i;
         end
         if (bit_cnt_q == CNT_LAST) begin
            keep_on_q  <= din_i;
            // the start bit is implied; only six command bits are in cmd_q yet
            cmd_done_q <= {1'b1, cmd_q[5:0], din_i};
         end
      end
   end

   // acquisition window, diode bias and pen diode switch
   always_ff @(posedge serial_clock_in_i) begin
      if (lrst || cs_n_i) begin
         sample_o          <= 1'b0;
         temp_bias_base_o  <= 1'b0;
         temp_bias_x91_o   <= 1'b0;
         pen_diode_sense_o <= 1'b0;
      end else if (state_q == ST_CMD && bit_cnt_q == CNT_ACQ) begin
         sample_o          <= 1'b1;
         temp_bias_base_o  <= (cmd_q[2:0] == CH_TEMP_BASE);
         temp_bias_x91_o   <= (cmd_q[2:0] == CH_TEMP_X91);
         pen_diode_sense_o <= (cmd_q[2:0] == CH_TEMP_BASE) || (cmd_q[2:0] == CH_TEMP_X91);
      end else if (state_q == ST_CMD && bit_cnt_q == CNT_LAST) begin
         sample_o         <= 1'b0;
         temp_bias_base_o <= 1'b0;
         temp_bias_x91_o  <= 1'b0;
      end else if (state_q == ST_CONV && conv_last) begin
         pen_diode_sense_o <= 1'b0;
      end
   end

   // panel drivers
   always_ff @(posedge serial_clock_in_i) begin
      if (lrst) begin
         drivers_o <= DRV_OFF;
      end else if (cs_n_i) begin
         // chip deselect turns the drivers off unless held; held drivers stay
         if (!keep_on_q) begin
            drivers_o <= DRV_OFF;
         end
      end else if (state_q == ST_CMD && bit_cnt_q == CNT_ACQ) begin
         drivers_o <= drv_for(cmd_q[2:0]);
      end else if (state_q == ST_CMD && bit_cnt_q == CNT_LAST) begin
         // single-ended hold releases the drivers unless told to stay on
         if (!ref_ratiometric_o && !din_i) begin
            drivers_o <= DRV_OFF;
         end
      end else if (state_q == ST_CONV && conv_last && !keep_on_q) begin
         drivers_o <= DRV_OFF;
      end
   end

   // successive approximation and serial result
   always_ff @(posedge serial_clock_in_i) begin
      if (lrst) begin
         res_sh_q   <= 12'h000;
         result_q   <= 12'h000;
         done_tgl_q <= 1'b0;
         dout_o     <= 1'b0;
         busy_o     <= 1'b0;
      end else begin
         if (cs_n_i) begin
            busy_o <= 1'b0;
            dout_o <= 1'b0;
         end else if (state_q == ST_CMD && bit_cnt_q == CNT_LAST) begin
            busy_o   <= 1'b1;
            res_sh_q <= 12'h000;
         end else if (state_q == ST_CONV) begin
            if (!(ref_ratiometric_o && bit_cnt_q == 4'h0)) begin
               res_sh_q <= res_next;
               dout_o   <= cmp_i;
            end
            if (conv_last) begin
               busy_o     <= 1'b0;
               // one code step is vref / CODE_STEPS at twelve bits
               result_q   <= mode8_q ? {4'h0, res_next[7:0]} : res_next;
               done_tgl_q <= !done_tgl_q;
            end
         end else begin
            dout_o <= 1'b0;
         end
      end
   end

   // ---------------- system domain ----------------
   logic        tgl_s;
   logic        tgl_d_q;
   logic [7:0]  stat_byte_q;
   logic [11:0] stat_result_q;
   logic [15:0] frames_q;
   logic        wb_req;
   logic        cs_n_s;

   // result and byte are held for a whole frame, far longer than the sync delay
   tac_sync #(.W(1)) u_tsync (
      .clk_i (clk_i),
      .d_i   (done_tgl_q),
      .q_o   (tgl_s)
   );

   // the pin enable follows chip select even while the host holds its clock still
   tac_sync #(.W(1)) u_csync (
      .clk_i (clk_i),
      .d_i   (cs_n_i),
      .q_o   (cs_n_s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dout_oe_o <= 1'b0;
      end else begin
         dout_oe_o <= !cs_n_s;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tgl_d_q       <= 1'b0;
         stat_byte_q   <= 8'h00;
         stat_result_q <= 12'h000;
         frames_q      <= FRAMES_RST;
      end else begin
         tgl_d_q <= tgl_s;
         if (tgl_s != tgl_d_q) begin
            stat_byte_q   <= cmd_done_q;
            stat_result_q <= result_q;
            frames_q      <= frames_q + 16'h0001;
         end
      end
   end

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_en_q <= CTRL_EN_RST;
      end else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == ADDR_CTRL) begin
         ctrl_en_q <= wb_dat_i[CTRL_EN_POS];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               ADDR_STATUS: wb_dat_o <= {24'h00_0000, stat_byte_q};
               ADDR_RESULT: wb_dat_o <= {20'h0_0000, stat_result_q};
               ADDR_CTRL:   wb_dat_o <= {31'h0000_0000, ctrl_en_q};
               ADDR_FRAMES: wb_dat_o <= {16'h0000, frames_q};
               default:     wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------- checks ----------------
   property p_acq_len;
      @(posedge serial_clock_in_i) disable iff (lrst || cs_n_i)
      $rose(sample_o) |-> sample_o[*3] ##1 !sample_o;
   endproperty
   a_acq_len: assert property (p_acq_len) else $error("acquisition not three clocks");

   property p_bias_only_acq;
      @(posedge serial_clock_in_i) disable iff (lrst)
      (temp_bias_base_o || temp_bias_x91_o) |-> sample_o;
   endproperty
   a_bias_only_acq: assert property (p_bias_only_acq) else $error("bias outside acquisition");

   property p_base_bias;
      @(posedge serial_clock_in_i) disable iff (lrst || cs_n_i)
      $rose(sample_o) && mux_select_o == CH_TEMP_BASE |-> temp_bias_base_o && !temp_bias_x91_o;
   endproperty
   a_base_bias: assert property (p_base_bias) else $error("base bias missing");

   property p_x91_bias;
      @(posedge serial_clock_in_i) disable iff (lrst || cs_n_i)
      $rose(sample_o) && mux_select_o == CH_TEMP_X91 |-> temp_bias_x91_o && !temp_bias_base_o;
   endproperty
   a_x91_bias: assert property (p_x91_bias) else $error("x91 bias missing");

   property p_pen_diode;
      @(posedge serial_clock_in_i) disable iff (lrst)
      (temp_bias_base_o || temp_bias_x91_o) |-> pen_diode_sense_o;
   endproperty
   a_pen_diode: assert property (p_pen_diode) else $error("pen diode off in temp cycle");

   property p_ref_power;
      @(posedge serial_clock_in_i) disable iff (lrst)
      !cs_n_i && state_q == ST_CMD && bit_cnt_q == CNT_REFPWR |=> ref_enable_o == $past(din_i);
   endproperty
   a_ref_power: assert property (p_ref_power) else $error("reference enable wrong");

   property p_ref_mode;
      @(posedge serial_clock_in_i) disable iff (lrst)
      !cs_n_i && state_q == ST_CMD && bit_cnt_q == CNT_REFMODE |=> ref_ratiometric_o != $past(din_i);
   endproperty
   a_ref_mode: assert property (p_ref_mode) else $error("reference routing wrong");

   property p_keep_on;
      @(posedge serial_clock_in_i) disable iff (lrst || cs_n_i)
      state_q == ST_CONV && conv_last && keep_on_q |=> drivers_o == $past(drivers_o);
   endproperty
   a_keep_on: assert property (p_keep_on) else $error("drivers dropped while held");

   property p_ratio_len;
      @(posedge serial_clock_in_i) disable iff (lrst || cs_n_i)
      $rose(busy_o) && ref_ratiometric_o && !mode8_q |-> ##12 busy_o ##1 !busy_o;
   endproperty
   a_ratio_len: assert property (p_ratio_len) else $error("ratiometric not 13 clocks");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule : tac_top
`default_nettype wire

// ==== dv/tac_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host end of the serial link; the link clock runs only inside frames and in deselected idle runs
module tac_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   output logic cmp_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
      cmp_o  = 1'b0;
   end
   // deselected clocks, to carry reset and the link enable into the link domain
   task automatic idle(input int n);
      repeat (n) begin
         din_o = ~din_o;
         #40 sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
      end
   endtask : idle
   // one 24-clock frame; outside its capture edges cmp_o keeps changing
   task automatic frame(input logic [7:0] b, input logic [11:0] code, input int pause_at);
      int idx;
      #7 cs_n_o = 1'b0;
      for (int k = 1; k <= 24; k++) begin
         din_o = (k <= 8) ? b[8-k] : 1'b0;
         idx = k - 9 - ((b[2] == 1'b0) ? 1 : 0);
         cmp_o = (idx >= 0 && idx < 12) ? code[11-idx] : ~cmp_o;
         #40 sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
         if (k == pause_at) #2000;
      end
      cs_n_o = 1'b1;
      din_o = ~din_o;
   endtask : frame
endmodule : tac_host_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tac_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [3:0]  wb_adr = 4'h0;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dw = 32'h0;
   logic [31:0] wb_dr;
   logic        wb_ack;
   logic        sclk, cs_n, din, cmp, dout, dout_oe, busy;
   logic        ref_en, ratio, bias_b, bias_x, pen, samp;
   logic [2:0]  mux;
   logic [3:0]  drv;
   logic [31:0] q;
   int          n_errors, compares, cycles, exp_frames;
   int          n_samp, n_base, n_x91, n_pen, n_busy, n_oe;
   logic [11:0] dsh = 12'h000;
   logic        busy_p = 1'b0;

   always #10 clk_i = ~clk_i;

   tac_host_model tac_host_model_i (
      .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .cmp_o(cmp));

   tac_top tac_top_i (
      .clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dw),
      .wb_dat_o(wb_dr), .wb_ack_o(wb_ack),
      .serial_clock_in_i(sclk), .cs_n_i(cs_n), .din_i(din),
      .dout_o(dout), .dout_oe_o(dout_oe), .busy_o(busy), .cmp_i(cmp),
      .ref_enable_o(ref_en), .ref_ratiometric_o(ratio), .mux_select_o(mux),
      .drivers_o(drv), .temp_bias_base_o(bias_b), .temp_bias_x91_o(bias_x),
      .pen_diode_sense_o(pen), .sample_o(samp));

   // registered link outputs seen before this edge's update
   always @(posedge sclk) begin
      if (cs_n === 1'b0) begin
         n_samp += int'(samp === 1'b1);
         n_base += int'(bias_b === 1'b1);
         n_x91 += int'(bias_x === 1'b1);
         n_pen += int'(pen === 1'b1);
         n_busy += int'(busy === 1'b1);
         n_oe += int'(dout_oe === 1'b1);
         // dout launched at the previous edge is read here
         if (busy_p) begin
            dsh = {dsh[10:0], dout};
         end
         busy_p = (busy === 1'b1);
      end
   end

   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_dw  <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      q = wb_dr;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      chk(n < 50, "no bus answer");
      if (n >= 50) begin
         stop_test();
      end
   endtask : wb

   task automatic run(input logic [7:0] b, input logic [11:0] code, input int pause_at,
                      input logic [3:0] drv_exp);
      logic temp;
      int   busy_exp;
      temp = (b[6:4] == CH_TEMP_BASE) || (b[6:4] == CH_TEMP_X91);
      busy_exp = (b[3] ? 8 : 12) + (b[2] ? 0 : 1);
      n_samp = 0;
      n_base = 0;
      n_x91 = 0;
      n_pen = 0;
      n_busy = 0;
      n_oe = 0;
      tac_host_model_i.frame(b, code, pause_at);
      repeat (8) @(posedge clk_i);
      exp_frames++;
      chk(ref_en === b[1], "reference enable");
      chk(ratio === ~b[2], "reference routing");
      chk(mux === b[6:4], "channel select");
      chk(drv === drv_exp, "drivers after frame");
      chk(n_samp == 3, "acquisition length");
      chk(n_base == ((b[6:4] == CH_TEMP_BASE) ? 3 : 0), "base bias");
      chk(n_x91 == ((b[6:4] == CH_TEMP_X91) ? 3 : 0), "x91 bias");
      chk(bias_b === 1'b0 && bias_x === 1'b0, "bias left on");
      chk((n_pen > 0) == temp, "pen diode sense");
      chk(n_busy == busy_exp, "conversion length");
      chk(n_oe >= 23, "output enable in frame");
      chk(dout_oe === 1'b0, "output enable released");
      chk(b[3] ? (dsh[7:0] === code[11:4]) : (dsh === code), "serial result");
      wb(1'b0, ADDR_RESULT, 32'h0);
      chk(q === {20'h0, b[3] ? {4'h0, code[11:4]} : code}, "result code");
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[7:0] === b, "control byte");
      wb(1'b0, ADDR_FRAMES, 32'h0);
      chk(q[15:0] === exp_frames[15:0], "frame count");
   endtask : run

   initial begin
      fork
         repeat (4) @(posedge clk_i);
         tac_host_model_i.idle(4);
      join
      @(posedge clk_i);
      rst_i <= 1'b0;
      tac_host_model_i.idle(4);
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk(q === {31'h0, CTRL_EN_RST}, "ctrl reset value");
      wb(1'b0, ADDR_FRAMES, 32'h0);
      chk(q === {16'h0, FRAMES_RST}, "frames reset value");
      wb(1'b0, 4'h2, 32'h0);
      chk(q === 32'h0, "unmapped read");
      run(8'hfc, 12'h9a6, 0, DRV_OFF);
      wb(1'b1, ADDR_STATUS, 32'h0);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[7:0] === 8'hfc, "read-only status written");
      run(8'h86, 12'h5c3, 7, DRV_OFF);
      run(8'hd1, 12'hc35, 0, DRV_X_PAIR);
      run(8'h91, 12'h3ac, 6, DRV_Y_PAIR);
      run(8'hb0, 12'h0f1, 0, DRV_OFF);
      // with the link disabled a start bit must be ignored
      wb(1'b1, ADDR_CTRL, 32'h0);
      // the enable reaches the link side only on link clock edges
      tac_host_model_i.idle(4);
      n_samp = 0;
      tac_host_model_i.frame(8'h86, 12'h0, 0);
      repeat (8) @(posedge clk_i);
      wb(1'b0, ADDR_FRAMES, 32'h0);
      chk(q[15:0] === exp_frames[15:0] && n_samp == 0, "disabled link converted");
      wb(1'b1, ADDR_CTRL, 32'h1);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
